// File: inc/presence_pkg.sv
// constants, types and helpers shared by the presence decision logic
// Behaviour
// - the presence pin is high while someone is judged present and low otherwise.
// - the serial link runs at 256000 baud, one stop bit, no parity unless reconfigured.
// - configuration written over the link is kept in non-volatile storage and reloaded at power-up.
// - the farthest distance is a count of range gates, each gate being 0.75 m deep.
// - motion and static detection each have their own farthest gate, settable from 1 to 8.
// - targets beyond the farthest gate are ignored and produce no result.
// - a gate reports a target only when its 0-100 energy is strictly above its threshold.
// - every gate has its own threshold, settable from 0 to 100.
// - a gate whose threshold is 100 never reports a target.
// - after detection stops, present is held for the configured seconds, restarted by any detection.
// - result frames carry the target state together with the target distances.
// - the wireless password is 6 bytes and must be supplied on connection before control is granted.
// - the wireless name ends with the last four hex digits of the MAC address.
// - result data goes over the wireless link only once the correct password has been given.
package presence_pkg;

    localparam int NGATE = 8;
    localparam int EW = 7;
    localparam logic [6:0] ENERGY_MAX = 7'h64;

    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned BAUD = 256_000;
    localparam int unsigned BAUD_CYC = CLK_HZ / BAUD;
    localparam int unsigned SEC_S = 1;
    localparam int unsigned SEC_CYC = SEC_S * CLK_HZ;

    // gate depth in centimetres
    localparam logic [15:0] GATE_CM = 16'h004B;
    localparam logic [3:0] GATE_MIN = 4'h1;
    localparam logic [3:0] GATE_MAX = 4'h8;

    localparam int CFG_AW = 5;
    localparam logic [4:0] CFG_MOT_MAX = 5'h00;
    localparam logic [4:0] CFG_STA_MAX = 5'h01;
    localparam logic [4:0] CFG_HOLD = 5'h02;
    localparam logic [4:0] CFG_MOT_THR = 5'h03;
    localparam logic [4:0] CFG_STA_THR = 5'h0B;
    localparam logic [4:0] CFG_PWD = 5'h13;
    localparam int CFG_N = 22;

    localparam logic [15:0] DEF_MAX = 16'h0008;
    localparam logic [15:0] DEF_HOLD = 16'h0005;
    localparam logic [15:0] DEF_THR = 16'h0032;
    // arbitrary neutral password, six ascii digits
    localparam logic [47:0] DEF_PWD = 48'h3132_3334_3536;

    localparam logic [7:0] FRM_HEAD = 8'hA5;
    localparam logic [7:0] FRM_TAIL = 8'h5A;
    localparam logic [2:0] FRM_LAST = 3'h6;
    localparam logic [2:0] PWD_LAST = 3'h5;

    typedef enum logic [3:0] {
        BOOT_REQ = 4'b0001,
        BOOT_WAIT = 4'b0010,
        BOOT_CAP = 4'b0100,
        BOOT_RUN = 4'b1000
    } boot_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } txst_t;

    function automatic logic [15:0] cfg_default(input logic [4:0] idx);
        if (idx == CFG_MOT_MAX || idx == CFG_STA_MAX) cfg_default = DEF_MAX;
        else if (idx == CFG_HOLD) cfg_default = DEF_HOLD;
        else if (idx < CFG_PWD) cfg_default = DEF_THR;
        else if (idx == CFG_PWD) cfg_default = DEF_PWD[47:32];
        else if (idx == CFG_PWD + 5'h01) cfg_default = DEF_PWD[31:16];
        else cfg_default = DEF_PWD[15:0];
    endfunction : cfg_default

endpackage : presence_pkg

// File: inc/byte_stream_if.sv
// byte stream with valid/ready between the frame builder and the serial transmitter
`timescale 1ns/1ns
interface byte_stream_if;
    logic [7:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : byte_stream_if

// File: rtl/serial_tx.sv
// serial transmitter, 8 data bits, no parity, one stop bit
`timescale 1ns/1ns
module serial_tx
    import presence_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // byte source
    byte_stream_if.snk bs,
    // line
    output logic line
);
    localparam logic [8:0] BIT_LAST = 9'(BAUD_CYC - 1);

    logic [9:0] shift_r;
    logic [3:0] bits_r;
    logic [8:0] baud_r;
    logic busy_r;
    logic line_r;

    wire take_w = bs.valid && !busy_r;
    wire bit_end_w = busy_r && (baud_r == BIT_LAST);

    assign bs.ready = !busy_r;
    assign line = line_r;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            shift_r <= 10'h3FF;
            bits_r <= 4'h0;
            baud_r <= 9'h000;
            busy_r <= 1'b0;
            line_r <= 1'b1;
        end else if (take_w) begin
            // stop, data lsb first, start: no parity bit
            shift_r <= {1'b1, bs.data, 1'b0};
            bits_r <= 4'h0;
            baud_r <= 9'h000;
            busy_r <= 1'b1;
            line_r <= 1'b0;
        end else if (bit_end_w) begin
            baud_r <= 9'h000;
            shift_r <= {1'b1, shift_r[9:1]};
            bits_r <= bits_r + 4'h1;
            line_r <= shift_r[1];
            busy_r <= (bits_r != 4'h9);
        end else if (busy_r) begin
            baud_r <= baud_r + 9'h001;
        end
    end
endmodule : serial_tx

// File: rtl/presence_decision.sv
// presence decision, hold-off, config store, result frames and wireless gate
`timescale 1ns/1ns
module presence_decision
    import presence_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = SEC_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // per-gate energies from signal processing
    input wire logic [NGATE*EW-1:0] motion_energy,
    input wire logic [NGATE*EW-1:0] static_energy,
    input wire logic frame_valid,
    // configuration access from the command parser
    input wire logic report_en,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [CFG_AW-1:0] cfg_addr,
    input wire logic [15:0] cfg_wdata,
    output logic [15:0] cfg_rdata,
    output logic cfg_rvalid,
    output logic cfg_ack,
    output logic cfg_err,
    output logic boot_done,
    // non-volatile store
    output logic nvm_rd,
    output logic nvm_wr,
    output logic [CFG_AW-1:0] nvm_addr,
    output logic [15:0] nvm_wdata,
    input wire logic [15:0] nvm_rdata,
    input wire logic nvm_blank,
    // wireless side
    input wire logic ble_conn,
    input wire logic [7:0] ble_rx_byte,
    input wire logic ble_rx_valid,
    input wire logic [47:0] mac_addr,
    output logic ble_auth,
    output logic [7:0] ble_tx_byte,
    output logic ble_tx_valid,
    output logic [31:0] name_suffix,
    // results
    output logic presence_out,
    output logic [7:0] target_state,
    output logic [15:0] mot_dist_cm,
    output logic [15:0] sta_dist_cm,
    output logic uart_tx
);
    localparam logic [26:0] SEC_LAST = 27'(SEC_CYCLES - 1);

    function automatic logic [15:0] clamp_cfg(input logic [4:0] idx, input logic [15:0] d);
        if (idx == CFG_MOT_MAX || idx == CFG_STA_MAX) begin
            if (d < {12'h000, GATE_MIN}) clamp_cfg = {12'h000, GATE_MIN};
            else if (d > {12'h000, GATE_MAX}) clamp_cfg = {12'h000, GATE_MAX};
            else clamp_cfg = d;
        end else if (idx >= CFG_MOT_THR && idx < CFG_PWD) begin
            clamp_cfg = (d > {9'h000, ENERGY_MAX}) ? {9'h000, ENERGY_MAX} : d;
        end else begin
            clamp_cfg = d;
        end
    endfunction : clamp_cfg

    // index of the nearest gate with a hit
    function automatic logic [3:0] nearest(input logic [NGATE-1:0] hits);
        nearest = 4'h0;
        for (int i = NGATE - 1; i >= 0; i--) begin
            if (hits[i]) nearest = 4'(i);
        end
    endfunction : nearest

    function automatic logic [15:0] gate_cm(input logic [3:0] g);
        gate_cm = 16'({12'h000, g} * GATE_CM);
    endfunction : gate_cm

    function automatic logic [7:0] hex_ascii(input logic [3:0] n);
        hex_ascii = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction : hex_ascii

    boot_t boot_r;
    txst_t tx_r;
    logic [15:0] cfg_mem_r [CFG_N];
    logic [4:0] boot_idx_r;
    logic [15:0] cfg_rdata_r;
    logic cfg_rvalid_r, cfg_ack_r, cfg_err_r;
    logic nvm_rd_r, nvm_wr_r;
    logic [4:0] nvm_addr_r;
    logic [15:0] nvm_wdata_r;
    logic present_r;
    logic [15:0] hold_cnt_r;
    logic [26:0] sec_cnt_r;
    logic [7:0] state_r;
    logic [15:0] mot_dist_r, sta_dist_r;
    logic go_r;
    logic [2:0] byte_idx_r;
    logic [7:0] snap_r [5];
    logic [2:0] pwd_idx_r;
    logic pwd_match_r, auth_r;
    logic [7:0] ble_tx_byte_r;
    logic ble_tx_valid_r;
    logic [31:0] suffix_r;

    byte_stream_if bs ();

    // configuration write path, shared by boot reload and host writes
    wire running_w = (boot_r == BOOT_RUN);
    wire addr_ok_w = (cfg_addr < 5'(CFG_N));
    wire host_ok_w = running_w && !report_en && addr_ok_w;
    wire host_wr_w = cfg_wr && host_ok_w;
    wire host_rd_w = cfg_rd && host_ok_w;
    wire boot_ld_w = (boot_r == BOOT_CAP) && !nvm_blank;
    wire [4:0] wr_idx_w = (boot_r == BOOT_CAP) ? boot_idx_r : cfg_addr;
    wire [15:0] wr_raw_w = (boot_r == BOOT_CAP) ? nvm_rdata : cfg_wdata;
    wire [15:0] wr_val_w = clamp_cfg(wr_idx_w, wr_raw_w);
    wire wr_any_w = host_wr_w || boot_ld_w;

    genvar gi;
    generate
        for (gi = 0; gi < CFG_N; gi++) begin : g_cfg
            localparam logic [15:0] RST = cfg_default(5'(gi));
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) cfg_mem_r[gi] <= RST;
                else if (wr_any_w && wr_idx_w == 5'(gi)) cfg_mem_r[gi] <= wr_val_w;
            end
        end
    endgenerate

    // per-gate decision
    wire [3:0] mot_max_w = cfg_mem_r[CFG_MOT_MAX][3:0];
    wire [3:0] sta_max_w = cfg_mem_r[CFG_STA_MAX][3:0];
    wire [NGATE-1:0] mot_hit_w;
    wire [NGATE-1:0] sta_hit_w;

    generate
        for (gi = 0; gi < NGATE; gi++) begin : g_gate
            wire [6:0] mt = cfg_mem_r[CFG_MOT_THR + 5'(gi)][6:0];
            wire [6:0] st = cfg_mem_r[CFG_STA_THR + 5'(gi)][6:0];
            wire [6:0] me = motion_energy[gi*EW +: EW];
            wire [6:0] se = static_energy[gi*EW +: EW];
            // gate n spans n*0.75 m to (n+1)*0.75 m, so a limit of n keeps gates below n
            wire m_in = (4'(gi) < mot_max_w);
            wire s_in = (4'(gi) < sta_max_w);
            // a threshold of 100 is masked even if a stray energy reads above range
            assign mot_hit_w[gi] = m_in && (me > mt) && (mt != ENERGY_MAX);
            assign sta_hit_w[gi] = s_in && (se > st) && (st != ENERGY_MAX);
        end
    endgenerate

    wire mot_any_w = |mot_hit_w;
    wire sta_any_w = |sta_hit_w;
    wire det_w = frame_valid && (mot_any_w || sta_any_w);
    wire sec_tick_w = (sec_cnt_r == SEC_LAST);
    wire [15:0] hold_w = cfg_mem_r[CFG_HOLD];

    // frame bytes and password bytes
    wire [7:0] tx_byte_w = (byte_idx_r == 3'h0) ? FRM_HEAD :
                           (byte_idx_r == FRM_LAST) ? FRM_TAIL : snap_r[byte_idx_r - 3'h1];
    wire tx_fire_w = bs.valid && bs.ready;
    wire [47:0] pwd_w = {cfg_mem_r[CFG_PWD], cfg_mem_r[CFG_PWD + 5'h01], cfg_mem_r[CFG_PWD + 5'h02]};
    wire [7:0] pwd_byte_w = pwd_w[6'(47 - 8 * pwd_idx_r) -: 8];
    wire pwd_eq_w = (ble_rx_byte == pwd_byte_w);

    assign bs.data = tx_byte_w;
    assign bs.valid = (tx_r == TX_SEND);

    // boot reload from the non-volatile store, one read per entry
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            boot_r <= BOOT_REQ;
            boot_idx_r <= 5'h00;
        end else begin
            case (boot_r)
                BOOT_REQ: boot_r <= BOOT_WAIT;
                BOOT_WAIT: boot_r <= BOOT_CAP;
                BOOT_CAP: begin
                    boot_idx_r <= boot_idx_r + 5'h01;
                    boot_r <= (boot_idx_r == 5'(CFG_N - 1)) ? BOOT_RUN : BOOT_REQ;
                end
                BOOT_RUN: boot_r <= BOOT_RUN;
                default: boot_r <= BOOT_REQ;
            endcase
        end
    end

    // host access and store writes
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            nvm_rd_r <= 1'b0;
            nvm_wr_r <= 1'b0;
            nvm_addr_r <= 5'h00;
            nvm_wdata_r <= 16'h0000;
            cfg_ack_r <= 1'b0;
            cfg_err_r <= 1'b0;
            cfg_rvalid_r <= 1'b0;
            cfg_rdata_r <= 16'h0000;
        end else begin
            nvm_rd_r <= (boot_r == BOOT_REQ);
            nvm_wr_r <= host_wr_w;
            if (boot_r == BOOT_REQ) nvm_addr_r <= boot_idx_r;
            else if (host_wr_w) nvm_addr_r <= cfg_addr;
            if (host_wr_w) nvm_wdata_r <= wr_val_w;
            cfg_ack_r <= host_wr_w;
            // access while reporting, booting or out of range is refused
            cfg_err_r <= (cfg_wr || cfg_rd) && !host_ok_w;
            cfg_rvalid_r <= host_rd_w;
            if (host_rd_w) cfg_rdata_r <= cfg_mem_r[cfg_addr];
        end
    end

    // presence with hold-off; the second counter restarts on detection so the window is whole seconds
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            present_r <= 1'b0;
            hold_cnt_r <= 16'h0000;
            sec_cnt_r <= 27'h000_0000;
        end else if (det_w) begin
            present_r <= 1'b1;
            hold_cnt_r <= 16'h0000;
            sec_cnt_r <= 27'h000_0000;
        end else begin
            sec_cnt_r <= sec_tick_w ? 27'h000_0000 : sec_cnt_r + 27'h000_0001;
            if (present_r && sec_tick_w) begin
                if (hold_cnt_r + 16'h0001 >= hold_w) present_r <= 1'b0;
                else hold_cnt_r <= hold_cnt_r + 16'h0001;
            end else if (present_r && hold_w == 16'h0000) begin
                present_r <= 1'b0;
            end
        end
    end

    // latest frame result
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= 8'h00;
            mot_dist_r <= 16'h0000;
            sta_dist_r <= 16'h0000;
            go_r <= 1'b0;
        end else begin
            go_r <= frame_valid && report_en && running_w;
            if (frame_valid) begin
                state_r <= {6'h00, sta_any_w, mot_any_w};
                mot_dist_r <= mot_any_w ? gate_cm(nearest(mot_hit_w)) : 16'h0000;
                sta_dist_r <= sta_any_w ? gate_cm(nearest(sta_hit_w)) : 16'h0000;
            end
        end
    end

    // frame sender; a frame arriving while one is in flight is dropped, not queued
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_r <= TX_IDLE;
            byte_idx_r <= 3'h0;
            for (int i = 0; i < 5; i++) snap_r[i] <= 8'h00;
        end else begin
            case (tx_r)
                TX_IDLE: if (go_r) begin
                    tx_r <= TX_SEND;
                    byte_idx_r <= 3'h0;
                    snap_r[0] <= {present_r, state_r[6:0]};
                    snap_r[1] <= mot_dist_r[7:0];
                    snap_r[2] <= mot_dist_r[15:8];
                    snap_r[3] <= sta_dist_r[7:0];
                    snap_r[4] <= sta_dist_r[15:8];
                end
                TX_SEND: if (tx_fire_w) begin
                    byte_idx_r <= byte_idx_r + 3'h1;
                    if (byte_idx_r == FRM_LAST) tx_r <= TX_IDLE;
                end
                default: tx_r <= TX_IDLE;
            endcase
        end
    end

    // wireless password check and forwarding
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pwd_idx_r <= 3'h0;
            pwd_match_r <= 1'b1;
            auth_r <= 1'b0;
            ble_tx_byte_r <= 8'h00;
            ble_tx_valid_r <= 1'b0;
        end else begin
            ble_tx_valid_r <= tx_fire_w && auth_r && ble_conn;
            if (tx_fire_w) ble_tx_byte_r <= tx_byte_w;
            if (!ble_conn) begin
                pwd_idx_r <= 3'h0;
                pwd_match_r <= 1'b1;
                auth_r <= 1'b0;
            end else if (ble_rx_valid && !auth_r) begin
                if (pwd_idx_r == PWD_LAST) begin
                    // wrong password restarts the six-byte entry
                    auth_r <= pwd_match_r && pwd_eq_w;
                    pwd_idx_r <= 3'h0;
                    pwd_match_r <= 1'b1;
                end else begin
                    pwd_idx_r <= pwd_idx_r + 3'h1;
                    pwd_match_r <= pwd_match_r && pwd_eq_w;
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) suffix_r <= 32'h3030_3030;
        else suffix_r <= {hex_ascii(mac_addr[15:12]), hex_ascii(mac_addr[11:8]),
                          hex_ascii(mac_addr[7:4]), hex_ascii(mac_addr[3:0])};
    end

    serial_tx u_tx (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .bs(bs),
        .line(uart_tx)
    );

    assign presence_out = present_r;
    assign target_state = state_r;
    assign mot_dist_cm = mot_dist_r;
    assign sta_dist_cm = sta_dist_r;
    assign cfg_rdata = cfg_rdata_r;
    assign cfg_rvalid = cfg_rvalid_r;
    assign cfg_ack = cfg_ack_r;
    assign cfg_err = cfg_err_r;
    assign boot_done = running_w;
    assign nvm_rd = nvm_rd_r;
    assign nvm_wr = nvm_wr_r;
    assign nvm_addr = nvm_addr_r;
    assign nvm_wdata = nvm_wdata_r;
    assign ble_auth = auth_r;
    assign ble_tx_byte = ble_tx_byte_r;
    assign ble_tx_valid = ble_tx_valid_r;
    assign name_suffix = suffix_r;

endmodule : presence_decision

// File: bench/presence_checker.sv
// port assertions for the presence decision block
`timescale 1ns/1ns
module presence_checker
    import presence_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // configuration
    input wire logic report_en,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [CFG_AW-1:0] cfg_addr,
    input wire logic cfg_ack,
    input wire logic cfg_err,
    input wire logic boot_done,
    input wire logic nvm_wr,
    input wire logic [CFG_AW-1:0] nvm_addr,
    // results
    input wire logic frame_valid,
    input wire logic presence_out,
    input wire logic [7:0] target_state,
    input wire logic [15:0] mot_dist_cm,
    input wire logic uart_tx,
    // wireless
    input wire logic ble_conn,
    input wire logic ble_auth,
    input wire logic ble_tx_valid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    wire logic acc = cfg_wr || cfg_rd;
    busy_refuse_a: assert property (acc && report_en |=> cfg_err && !cfg_ack && !nvm_wr)
        else $error("access while reporting not refused");
    boot_refuse_a: assert property (acc && !boot_done |=> cfg_err)
        else $error("access while booting not refused");
    write_store_a: assert property (cfg_wr && boot_done && !report_en && cfg_addr < 5'h16 |=>
        cfg_ack && nvm_wr && nvm_addr == $past(cfg_addr))
        else $error("accepted write not stored");
    hit_present_a: assert property (frame_valid |=> target_state[1:0] == 2'b00 || presence_out)
        else $error("hit without presence");
    clean_fall_a: assert property ($fell(presence_out) |-> !$past(frame_valid) || target_state[1:0] == 2'b00)
        else $error("presence fell after a hit");
    motion_dist_a: assert property (frame_valid |=> (target_state[0] || mot_dist_cm == 16'h0000)
        && mot_dist_cm % 16'h004B == 16'h0000 && mot_dist_cm < 16'h0258)
        else $error("motion distance off the gate grid");
    auth_clear_a: assert property (!ble_conn |=> !ble_auth)
        else $error("auth kept without link");
    wireless_gate_a: assert property (ble_tx_valid |-> ble_auth)
        else $error("wireless data before auth");
    boot_idle_a: assert property (!boot_done |-> uart_tx)
        else $error("serial activity during boot");
    start_bit_a: assert property ($fell(uart_tx) |-> !uart_tx [*8])
        else $error("start bit too short");
endmodule : presence_checker

bind presence_decision presence_checker i_presence_checker (.*);

// File: bench/host_model.sv
// host side: configuration store and serial result receiver
`timescale 1ns/1ns
module host_model
    import presence_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // store
    input wire logic nvm_rd,
    input wire logic nvm_wr,
    input wire logic [CFG_AW-1:0] nvm_addr,
    input wire logic [15:0] nvm_wdata,
    output logic [15:0] nvm_rdata,
    output logic nvm_blank,
    // serial line
    input wire logic uart_tx
);
    logic [15:0] mem [CFG_N];
    logic [8:0] rx_q [$];
    logic [8:0] sh;
    logic hold_r;
    initial begin
        foreach (mem[i]) mem[i] = 16'h0032;
        mem[2] = 16'h0003;
        mem[19] = 16'h4142;
        mem[20] = 16'h4344;
        mem[21] = 16'h4546;
        nvm_blank = 1'b0;
        nvm_rdata = 16'h0000;
        hold_r = 1'b0;
    end
    always @(posedge ref_clk) begin
        hold_r <= nvm_rd;
        if (nvm_wr) mem[nvm_addr] <= nvm_wdata;
        if (nvm_rd) nvm_rdata <= mem[nvm_addr];
        // released bus shows the inverse
        else if (!hold_r) nvm_rdata <= ~nvm_rdata;
    end
    // 8N1 lsb first, bit 8 keeps the stop level
    initial begin
        forever begin
            @(negedge uart_tx);
            repeat (BAUD_CYC / 2) @(posedge ref_clk);
            for (int b = 0; b < 9; b++) begin
                repeat (BAUD_CYC) @(posedge ref_clk);
                sh[b] = uart_tx;
            end
            rx_q.push_back(sh);
        end
    end
endmodule : host_model

// File: bench/presence_decision_tb_top.sv
// self-checking bench for the presence decision block
`timescale 1ns/1ns
module presence_decision_tb_top
    import presence_pkg::*;
    ;
    logic ref_clk, arst_n, frame_valid, report_en, cfg_wr, cfg_rd, cfg_rvalid, cfg_ack, cfg_err;
    logic boot_done, nvm_rd, nvm_wr, nvm_blank, ble_conn, ble_rx_valid, ble_auth, ble_tx_valid;
    logic presence_out, uart_tx;
    logic [NGATE*EW-1:0] motion_energy, static_energy;
    logic [CFG_AW-1:0] cfg_addr, nvm_addr;
    logic [15:0] cfg_wdata, cfg_rdata, nvm_wdata, nvm_rdata, mot_dist_cm, sta_dist_cm;
    logic [7:0] ble_rx_byte, ble_tx_byte, target_state;
    logic [47:0] mac_addr;
    logic [31:0] name_suffix;
    int errors, check_count, ble_cnt;
    presence_decision #(.SEC_CYCLES(100)) i_presence_decision (.*);
    host_model i_host_model (.*);
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) if (ble_tx_valid === 1'b1) ble_cnt <= ble_cnt + 1;
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic timeout();
        chk(1'b0, 1'b1, "wait limit");
        conclude();
    endtask : timeout
    function automatic logic [NGATE*EW-1:0] g(input int n, input logic [6:0] v);
        g = {49'h0, v} << (7 * n);
    endfunction : g
    // one config access; rsp is {err, ack, rvalid} in the answer cycle
    task automatic acc(input logic w, input logic [4:0] a, input logic [15:0] d, input logic [2:0] rsp,
                       input logic [15:0] rd);
        @(posedge ref_clk);
        cfg_wr <= w;
        cfg_rd <= !w;
        cfg_addr <= a;
        cfg_wdata <= d;
        @(posedge ref_clk);
        cfg_wr <= 1'b0;
        cfg_rd <= 1'b0;
        #1;
        chk({cfg_err, cfg_ack, cfg_rvalid}, rsp, "cfg answer");
        if (rsp == 3'b001) chk(cfg_rdata, rd, "cfg data");
    endtask : acc
    task automatic frm(input logic [55:0] m, input logic [55:0] s, input logic [7:0] st,
                       input logic [15:0] md, input logic [15:0] sd);
        @(posedge ref_clk);
        motion_energy <= m;
        static_energy <= s;
        frame_valid <= 1'b1;
        @(posedge ref_clk);
        frame_valid <= 1'b0;
        #1;
        chk(target_state, st, "state");
        chk(mot_dist_cm, md, "motion dist");
        chk(sta_dist_cm, sd, "static dist");
    endtask : frm
    task automatic pwd(input logic [47:0] p);
        for (int i = 0; i < 6; i++) begin
            @(posedge ref_clk);
            ble_rx_byte <= p[47 - 8 * i -: 8];
            ble_rx_valid <= 1'b1;
            @(posedge ref_clk);
            ble_rx_valid <= 1'b0;
        end
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : pwd
    task automatic t_boot();
        int n;
        acc(1'b0, 5'h02, 16'h0000, 3'b100, 16'h0000);
        for (n = 0; boot_done !== 1'b1 && n < 200; n++) @(posedge ref_clk);
        if (n >= 200) timeout();
        acc(1'b0, 5'h02, 16'h0000, 3'b001, 16'h0003);
        acc(1'b0, 5'h15, 16'h0000, 3'b001, 16'h4546);
        chk(name_suffix, 32'h3941_3346, "name suffix");
    endtask : t_boot
    task automatic t_cfg();
        acc(1'b1, 5'h03, 16'h0014, 3'b010, 16'h0000);
        acc(1'b0, 5'h03, 16'h0000, 3'b001, 16'h0014);
        chk(i_host_model.mem[3], 16'h0014, "stored word");
        acc(1'b1, 5'h04, 16'h0065, 3'b010, 16'h0000);
        acc(1'b0, 5'h04, 16'h0000, 3'b001, 16'h0064);
        acc(1'b1, 5'h00, 16'h0000, 3'b010, 16'h0000);
        acc(1'b0, 5'h00, 16'h0000, 3'b001, 16'h0001);
        acc(1'b1, 5'h00, 16'h0009, 3'b010, 16'h0000);
        acc(1'b0, 5'h00, 16'h0000, 3'b001, 16'h0008);
        acc(1'b0, 5'h16, 16'h0000, 3'b100, 16'h0000);
        @(posedge ref_clk);
        report_en <= 1'b1;
        acc(1'b1, 5'h03, 16'h0063, 3'b100, 16'h0000);
        @(posedge ref_clk);
        report_en <= 1'b0;
        acc(1'b0, 5'h03, 16'h0000, 3'b001, 16'h0014);
        acc(1'b1, 5'h03, 16'h0032, 3'b010, 16'h0000);
    endtask : t_cfg
    task automatic t_gates();
        frm(g(2, 7'h33), '0, 8'h01, 16'h0096, 16'h0000);
        chk(presence_out, 1'b1, "present");
        frm(g(2, 7'h32), '0, 8'h00, 16'h0000, 16'h0000);
        frm(g(1, 7'h7F), '0, 8'h00, 16'h0000, 16'h0000);
        acc(1'b1, 5'h00, 16'h0002, 3'b010, 16'h0000);
        frm(g(2, 7'h5A), '0, 8'h00, 16'h0000, 16'h0000);
        acc(1'b1, 5'h00, 16'h0003, 3'b010, 16'h0000);
        frm(g(2, 7'h5A), '0, 8'h01, 16'h0096, 16'h0000);
        frm('0, g(7, 7'h3C) | g(5, 7'h3D), 8'h02, 16'h0000, 16'h0177);
    endtask : t_gates
    // hold is 3 s of 100 cycles; hits every 192 cycles must keep presence up
    task automatic t_hold();
        int lows;
        int n;
        lows = 0;
        for (int k = 0; k < 4; k++) begin
            frm(g(2, 7'h33), '0, 8'h01, 16'h0096, 16'h0000);
            repeat (190) begin
                @(posedge ref_clk);
                #1;
                if (presence_out !== 1'b1) lows++;
            end
        end
        chk(lows, 0, "held present");
        frm('0, '0, 8'h00, 16'h0000, 16'h0000);
        for (n = 0; presence_out !== 1'b0 && n < 400; n++) @(negedge ref_clk);
        if (n >= 400) timeout();
        chk(n, 109, "hold length");
    endtask : t_hold
    task automatic t_link();
        logic [7:0] eb [7] = '{8'hA5, 8'h83, 8'h96, 8'h00, 8'hE1, 8'h00, 8'h5A};
        int n;
        @(posedge ref_clk);
        report_en <= 1'b1;
        ble_conn <= 1'b1;
        pwd(48'h4142_4344_4558);
        chk(ble_auth, 1'b0, "bad password");
        pwd(48'h4142_4344_4546);
        chk(ble_auth, 1'b1, "good password");
        frm(g(2, 7'h33), g(3, 7'h3C), 8'h03, 16'h0096, 16'h00E1);
        for (n = 0; i_host_model.rx_q.size() < 7 && n < 40000; n++) @(posedge ref_clk);
        if (n >= 40000) timeout();
        foreach (eb[i]) chk(i_host_model.rx_q[i], {1'b1, eb[i]}, "serial byte");
        chk(ble_cnt, 7, "wireless copies");
        chk(ble_tx_byte, 8'h5A, "ble tail");
        @(posedge ref_clk);
        ble_conn <= 1'b0;
        report_en <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk(ble_auth, 1'b0, "auth dropped");
    endtask : t_link
    initial begin
        {arst_n, frame_valid, report_en, cfg_wr, cfg_rd, ble_conn, ble_rx_valid} = '0;
        {motion_energy, static_energy, cfg_addr, cfg_wdata, ble_rx_byte} = '0;
        mac_addr = 48'h0000_0000_9A3F;
        {errors, check_count, ble_cnt} = '0;
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_boot();
        t_cfg();
        t_gates();
        t_hold();
        t_link();
        conclude();
    end
endmodule : presence_decision_tb_top
